// ==== hdl/hpad_pkg.sv ====
// Shared types and constants for the host port access decoder
package hpad_pkg;

    // Major operating modes of the host port
    typedef enum logic [1:0] {
        MODE_MUX_HALF,
        MODE_MUX_FULL,
        MODE_NONMUX_FULL
    } hpad_mode_e;

    // Access type codes on the access type select pins
    localparam logic [1:0] CMD_CTRL = 2'h0;
    localparam logic [1:0] CMD_DATA_INC = 2'h1;
    localparam logic [1:0] CMD_ADDR = 2'h2;
    localparam logic [1:0] CMD_DATA = 2'h3;

    // Address step after an incrementing data access, in bytes
    localparam logic [31:0] ADDR_STEP = 32'h4;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [31:0] ADDR_RST = 32'h0;

    // Buffer geometry
    localparam int BUF_DEPTH = 2;

    // Internal access sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_RD_WAIT
    } hpad_st_e;

    // Host pins sampled together
    typedef struct packed {
        logic cs_n;
        logic [1:0] ds_n;
        logic [1:0] cmd;
        logic rnw;
        logic hw;
        logic [3:0] be;
        logic [15:0] addr;
        logic [31:0] data;
    } hpad_pins_s;

    // Request towards the internal address space
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } hpad_req_s;

endpackage : hpad_pkg

// ==== hdl/hpad_req_buf.sv ====
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/1ps
module hpad_req_buf (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    input hpad_pkg::hpad_req_s in_req,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output hpad_pkg::hpad_req_s out_req,
    input wire logic out_ready
);

    typedef struct packed {
        hpad_pkg::hpad_req_s [hpad_pkg::BUF_DEPTH-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } hpad_buf_s;

    hpad_buf_s s;
    hpad_buf_s next_s;
    logic push;
    logic pop;

    always_comb begin
        in_ready = (s.cnt != 2'h2);
        out_valid = (s.cnt != 2'h0);
        out_req = s.mem[s.rd];
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_req;
            next_s.wr = ~s.wr;
        end
        if (pop) begin
            next_s.rd = ~s.rd;
        end
        case ({push, pop})
            2'b10: next_s.cnt = s.cnt + 2'h1;
            2'b01: next_s.cnt = s.cnt - 2'h1;
            default: next_s.cnt = s.cnt;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : hpad_req_buf

// ==== hdl/hpad_host_port.sv ====
// Host port front end: strobe decode, access typing and internal requests
//
// Behaviour
// - The port runs in one of three modes: muxed half-word, muxed fullword or non-muxed fullword.
// - Chip select and the two data strobes are combined into one internal access strobe.
// - Address and access control inputs are captured when the internal strobe goes active.
// - Write data is captured when the internal strobe goes inactive.
// - Ready is driven not-ready only while the internal strobe is active.
// - Code 00 targets the port control register in every mode.
// - Code 01 is a data access at the current address, followed by an advance in muxed modes only.
// - Code 10 targets the port address register in every mode; writes to it take effect in muxed modes only.
// - Code 11 is a data access that leaves the address unchanged, in every mode.
// - In muxed fullword mode all 32 data lines carry each access in one host cycle.
// - Ready is held not-ready to insert wait states until the internal operation of a data read is done; writes are posted after the strobe ends.
`timescale 1ns/1ps
module hpad_host_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Configuration
    input hpad_pkg::hpad_mode_e major_mode,
    input wire logic [15:0] page_base,
    // Host pins
    input wire logic host_chip_select_n,
    input wire logic [1:0] host_data_strobes_n,
    input wire logic [1:0] access_type_select,
    input wire logic host_read_not_write,
    input wire logic half_word_select,
    input wire logic [3:0] host_byte_enables,
    input wire logic [15:0] host_addr,
    input wire logic [31:0] host_data_bus_in,
    output logic [31:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    output logic host_ready_out,
    // Internal request stream
    output logic mem_req_valid,
    output hpad_pkg::hpad_req_s mem_req,
    input wire logic mem_req_ready,
    // Internal read response
    input wire logic mem_rsp_valid,
    input wire logic [31:0] mem_rsp_data,
    // Port control register contents
    output logic [31:0] port_control_register
);

    typedef struct packed {
        hpad_pkg::hpad_pins_s sync1;
        hpad_pkg::hpad_pins_s sync2;
        logic strobe_d;
        logic [1:0] cmd;
        logic rnw;
        logic hw;
        logic [3:0] be;
        logic [15:0] pin_addr;
        logic [31:0] ctrl;
        logic [31:0] addr;
        logic [31:0] rdata;
        logic [15:0] wlow;
        logic [31:0] wdata;
        logic go;
        logic req_write;
        hpad_pkg::hpad_st_e st;
        logic [31:0] dout;
        logic drive_n;
    } hpad_state_s;

    hpad_state_s s;
    hpad_state_s next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    hpad_pkg::hpad_pins_s pins;
    hpad_pkg::hpad_pins_s pn;
    logic strobe;
    logic start;
    logic stop;
    logic half;
    logic nonmux;
    logic data_cmd;
    logic start_need;
    logic busy;
    logic [31:0] wd;
    logic [31:0] cur_addr;
    logic [31:0] sel;
    logic buf_in_valid;
    logic buf_in_ready;
    hpad_pkg::hpad_req_s buf_in_req;

    // Reset release through two flip-flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign pins = '{cs_n: host_chip_select_n, ds_n: host_data_strobes_n,
                    cmd: access_type_select, rnw: host_read_not_write,
                    hw: half_word_select, be: host_byte_enables,
                    addr: host_addr, data: host_data_bus_in};

    always_comb begin
        next_s = s;
        pn = s.sync2;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        half = (major_mode == hpad_pkg::MODE_MUX_HALF);
        nonmux = (major_mode == hpad_pkg::MODE_NONMUX_FULL);
        strobe = ~pn.cs_n & (pn.ds_n[1] ^ pn.ds_n[0]);
        next_s.strobe_d = strobe;
        start = strobe & ~s.strobe_d;
        stop = ~strobe & s.strobe_d;
        cur_addr = nonmux ? {page_base, s.pin_addr} : s.addr;
        data_cmd = (s.cmd == hpad_pkg::CMD_DATA_INC) | (s.cmd == hpad_pkg::CMD_DATA);
        start_need = start & pn.rnw & pn.cmd[0] & ~(half & pn.hw);
        busy = s.go | (s.st != hpad_pkg::ST_IDLE) | start_need;
        wd = half ? {pn.data[15:0], s.wlow} : pn.data;
        buf_in_valid = 1'b0;
        buf_in_req = '{write: s.req_write, addr: cur_addr, be: s.be, data: s.wdata};

        // Capture address and control as the strobe goes active
        if (start) begin
            next_s.cmd = pn.cmd;
            next_s.rnw = pn.rnw;
            next_s.hw = pn.hw;
            next_s.be = pn.be;
            next_s.pin_addr = pn.addr;
            if (start_need) begin
                next_s.go = 1'b1;
                next_s.req_write = 1'b0;
            end
            // Second half of an incrementing half-word read advances the address
            if (half & pn.hw & pn.rnw & (pn.cmd == hpad_pkg::CMD_DATA_INC)) begin
                next_s.addr = s.addr + hpad_pkg::ADDR_STEP;
            end
        end

        // Capture write data as the strobe goes inactive
        if (stop & ~s.rnw) begin
            if (half & ~s.hw) begin
                next_s.wlow = pn.data[15:0];
            end else begin
                next_s.wdata = wd;
                case (s.cmd)
                    hpad_pkg::CMD_CTRL: next_s.ctrl = wd;
                    hpad_pkg::CMD_ADDR: begin
                        if (!nonmux) begin
                            next_s.addr = wd;
                        end
                    end
                    default: begin
                        next_s.go = 1'b1;
                        next_s.req_write = 1'b1;
                    end
                endcase
            end
        end

        // Internal access sequencer
        case (s.st)
            hpad_pkg::ST_IDLE: begin
                if (s.go) begin
                    next_s.go = 1'b0;
                    next_s.st = hpad_pkg::ST_REQ;
                end
            end
            hpad_pkg::ST_REQ: begin
                buf_in_valid = 1'b1;
                if (buf_in_ready) begin
                    if (s.req_write) begin
                        next_s.st = hpad_pkg::ST_IDLE;
                        if (s.cmd == hpad_pkg::CMD_DATA_INC && !nonmux) begin
                            next_s.addr = s.addr + hpad_pkg::ADDR_STEP;
                        end
                    end else begin
                        next_s.st = hpad_pkg::ST_RD_WAIT;
                    end
                end
            end
            hpad_pkg::ST_RD_WAIT: begin
                if (mem_rsp_valid) begin
                    next_s.rdata = mem_rsp_data;
                    next_s.st = hpad_pkg::ST_IDLE;
                    if (s.cmd == hpad_pkg::CMD_DATA_INC && !nonmux && !half) begin
                        next_s.addr = s.addr + hpad_pkg::ADDR_STEP;
                    end
                end
            end
            default: next_s.st = hpad_pkg::ST_IDLE;
        endcase

        // Read data selection by access type and half
        case (s.cmd)
            hpad_pkg::CMD_CTRL: sel = s.ctrl;
            hpad_pkg::CMD_ADDR: sel = s.addr;
            default: begin
                sel = s.rdata;
                // Answer word goes out with the edge that ends the wait
                if (s.st == hpad_pkg::ST_RD_WAIT && mem_rsp_valid) begin
                    sel = mem_rsp_data;
                end
            end
        endcase
        next_s.dout = (half & s.hw) ? {16'h0, sel[31:16]} : sel;
        if (half & ~s.hw) begin
            next_s.dout = {16'h0, sel[15:0]};
        end
        next_s.drive_n = ~(strobe & pn.rnw);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl <= hpad_pkg::CTRL_RST;
            s.addr <= hpad_pkg::ADDR_RST;
            s.drive_n <= 1'b1;
            s.st <= hpad_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    hpad_req_buf u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(buf_in_valid),
        .in_req(buf_in_req),
        .in_ready(buf_in_ready),
        .out_valid(mem_req_valid),
        .out_req(mem_req),
        .out_ready(mem_req_ready)
    );

    assign host_ready_out = ~(strobe & busy);
    assign host_data_bus_out = s.dout;
    assign host_data_bus_oe_n = s.drive_n;
    assign port_control_register = s.ctrl;

endmodule : hpad_host_port

// ==== tb/hpad_host_port_chk.sv ====
// Concurrent checks on the host port front end
`timescale 1ns/1ps
module hpad_host_port_chk (
    // Clock, reset and configuration
    input wire logic mclk,
    input wire logic reset_n,
    input hpad_pkg::hpad_mode_e major_mode,
    input wire logic [15:0] page_base,
    input wire logic [15:0] host_addr,
    // Host pins
    input wire logic host_chip_select_n,
    input wire logic host_read_not_write,
    input wire logic [1:0] host_data_strobes_n,
    input wire logic [1:0] access_type_select,
    input wire logic host_data_bus_oe_n,
    input wire logic host_ready_out,
    input wire logic [31:0] host_data_bus_out,
    input wire logic [31:0] port_control_register,
    // Internal side
    input wire logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [31:0] mem_rsp_data,
    input hpad_pkg::hpad_req_s mem_req
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire act = !host_chip_select_n && (host_data_strobes_n[1] != host_data_strobes_n[0]);
    property p_rdy_gate;
        !host_ready_out |-> act || $past(act) || $past(act, 2) || $past(act, 3);
    endproperty
    a_rdy_gate: assert property (p_rdy_gate) else $error("ready low off strobe");
    property p_oe_gate;
        !host_data_bus_oe_n |-> host_read_not_write && (act || $past(act) || $past(act, 3));
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("bus driven off read");
    property p_rdy_bound;
        $fell(host_ready_out) |-> ##[1:300] host_ready_out;
    endproperty
    a_rdy_bound: assert property (p_rdy_bound) else $error("wait state stuck");
    property p_buf_hold;
        mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("request lost in stall");
    property p_rd_data;
        mem_rsp_valid && !host_data_bus_oe_n && major_mode == hpad_pkg::MODE_MUX_FULL
            |-> ##2 host_ready_out && host_data_bus_out == $past(mem_rsp_data, 2);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data late");
    property p_nm_addr;
        mem_req_valid && major_mode == hpad_pkg::MODE_NONMUX_FULL
            |-> mem_req.addr == {page_base, host_addr};
    endproperty
    a_nm_addr: assert property (p_nm_addr) else $error("page address wrong");
    property p_ctrl_src;
        $changed(port_control_register) |-> !$past(host_read_not_write, 2)
            && $past(access_type_select, 2) == hpad_pkg::CMD_CTRL;
    endproperty
    a_ctrl_src: assert property (p_ctrl_src) else $error("control reg bad write");
    property p_rd_wait;
        mem_req_valid && !mem_req.write |-> !host_ready_out;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read without wait");
    c_rd: cover property (mem_rsp_valid);
    c_stall: cover property (mem_req_valid && !mem_req_ready);
    c_wr: cover property (mem_req_valid && mem_req_ready && mem_req.write);
endmodule : hpad_host_port_chk
bind hpad_host_port hpad_host_port_chk u_chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .major_mode(major_mode),
    .page_base(page_base),
    .host_addr(host_addr),
    .host_chip_select_n(host_chip_select_n),
    .host_read_not_write(host_read_not_write),
    .host_data_strobes_n(host_data_strobes_n),
    .access_type_select(access_type_select),
    .host_data_bus_oe_n(host_data_bus_oe_n),
    .host_ready_out(host_ready_out),
    .host_data_bus_out(host_data_bus_out),
    .port_control_register(port_control_register),
    .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data),
    .mem_req(mem_req)
);

// ==== tb/hpad_host_model.sv ====
// Host microcontroller model driving the parallel host pins
`timescale 1ns/1ps
module hpad_host_model (
    // Clock and port answer
    input wire logic mclk,
    input wire logic ready,
    input wire logic [31:0] rdata,
    // Host pins
    output logic cs_n,
    output logic rnw,
    output logic hw,
    output logic [1:0] ds_n,
    output logic [1:0] cmd,
    output logic [3:0] be,
    output logic [15:0] addr,
    output logic [31:0] data
);
    initial begin
        {cs_n, ds_n, cmd, rnw, hw, addr, data} = {3'h7, 52'h0};
        be = 4'hf;
    end
    task xfer(input logic [1:0] c, rh, input logic [15:0] a, input logic [31:0] d,
              output logic [31:0] q);
        int n;
        @(posedge mclk);
        #2;
        {cmd, rnw, hw, addr, data} = {c, rh, a, d};
        {cs_n, ds_n} = 3'h1;
        repeat (5) @(posedge mclk);
        n = 0;
        while (ready !== 1'h1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        q = rdata;
        #2;
        {cs_n, ds_n} = 3'h7;
        // Write data held past the strobe end
        repeat (3) @(posedge mclk);
        #2;
        data = ~d;
        repeat (3) @(posedge mclk);
    endtask : xfer
endmodule : hpad_host_model

// ==== tb/hpad_host_port_tb_top.sv ====
// Self-checking bench for the host port front end
`timescale 1ns/1ps
module hpad_host_port_tb_top;
    logic mclk = 1'h0, reset_n = 1'h0, stall = 1'h0, rsp_v = 1'h0;
    logic [2:0] rc = 3'h0;
    logic [15:0] page = 16'h0, ha = 16'h0, addr;
    logic [31:0] rsp_d = 32'h0, q, q1, dout, pcr, hd;
    logic cs_n, rnw, hw, oe_n, rdy, req_v;
    logic [1:0] ds_n, cmd;
    logic [3:0] be;
    hpad_pkg::hpad_mode_e mode = hpad_pkg::MODE_MUX_FULL;
    hpad_pkg::hpad_req_s req;
    hpad_pkg::hpad_req_s reqs[$];
    int fail_count = 0, checked = 0, cyc = 0;
    wire [31:0] bus = !oe_n ? dout : hd;
    hpad_host_model host (.mclk(mclk), .ready(rdy), .rdata(bus), .cs_n(cs_n), .rnw(rnw),
        .hw(hw), .ds_n(ds_n), .cmd(cmd), .be(be), .addr(addr), .data(hd));
    hpad_host_port dut (.mclk(mclk), .reset_n(reset_n), .major_mode(mode), .page_base(page),
        .host_chip_select_n(cs_n), .host_data_strobes_n(ds_n), .access_type_select(cmd),
        .host_read_not_write(rnw), .half_word_select(hw), .host_byte_enables(be),
        .host_addr(addr), .host_data_bus_in(bus), .host_data_bus_out(dout),
        .host_data_bus_oe_n(oe_n), .host_ready_out(rdy), .mem_req_valid(req_v),
        .mem_req(req), .mem_req_ready(!stall), .mem_rsp_valid(rsp_v),
        .mem_rsp_data(rsp_d), .port_control_register(pcr));
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rsp_v <= #2 (rc == 3'h1);
        if (rc != 3'h0) rc <= rc - 3'h1;
        if (req_v && !stall) begin
            reqs.push_back(req);
            if (!req.write) rc <= 3'h3;
            rsp_d <= #2 ~req.addr;
        end
        if (cyc == 5000) begin
            $display("[FAIL] %0t timeout", $time);
            fail_count++;
            results();
        end
    end
    task chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task chk_req(input logic w, input logic [31:0] a, d);
        hpad_pkg::hpad_req_s r;
        int n;
        n = 0;
        while (reqs.size() == 0 && n < 60) begin
            @(posedge mclk);
            n++;
        end
        r = (reqs.size() != 0) ? reqs.pop_front() : 'x;
        chk({31'h0, r.write}, {31'h0, w});
        chk(r.addr, a);
        chk(w ? r.data : d, d);
        chk({28'h0, r.be}, 32'hf);
    endtask : chk_req
    task rst(input hpad_pkg::hpad_mode_e m);
        @(posedge mclk);
        #2;
        reset_n = 1'h0;
        mode = m;
        repeat (3) @(posedge mclk);
        chk({30'h0, rdy, oe_n}, 32'h3);
        chk(pcr, hpad_pkg::CTRL_RST);
        #2;
        reset_n = 1'h1;
        repeat (4) @(posedge mclk);
        reqs.delete();
    endtask : rst
    task x(input logic [1:0] c, rh, input logic [31:0] d);
        host.xfer(c, rh, ha, d, q);
    endtask : x
    task t_ctrl;
        rst(hpad_pkg::MODE_MUX_FULL);
        x(hpad_pkg::CMD_CTRL, 2'h0, 32'h5a5a_0003);
        chk(pcr, 32'h5a5a_0003);
        x(hpad_pkg::CMD_CTRL, 2'h2, 32'h0);
        chk(q, 32'h5a5a_0003);
        $display("test control done");
    endtask : t_ctrl
    task t_inc;
        rst(hpad_pkg::MODE_MUX_FULL);
        x(hpad_pkg::CMD_ADDR, 2'h0, 32'h1000);
        x(hpad_pkg::CMD_DATA_INC, 2'h0, 32'hcafe_0001);
        chk_req(1'h1, 32'h1000, 32'hcafe_0001);
        x(hpad_pkg::CMD_DATA_INC, 2'h0, 32'hcafe_0002);
        chk_req(1'h1, 32'h1000 + hpad_pkg::ADDR_STEP, 32'hcafe_0002);
        x(hpad_pkg::CMD_DATA, 2'h2, 32'h0);
        chk_req(1'h0, 32'h1008, 32'h0);
        chk(q, ~32'h1008);
        x(hpad_pkg::CMD_DATA, 2'h2, 32'h0);
        chk_req(1'h0, 32'h1008, 32'h0);
        $display("test increment done");
    endtask : t_inc
    task t_half;
        rst(hpad_pkg::MODE_MUX_HALF);
        x(hpad_pkg::CMD_ADDR, 2'h0, 32'h0040);
        x(hpad_pkg::CMD_ADDR, 2'h1, 32'h0001);
        x(hpad_pkg::CMD_DATA_INC, 2'h2, 32'h0);
        q1 = q;
        x(hpad_pkg::CMD_DATA_INC, 2'h3, 32'h0);
        chk_req(1'h0, 32'h0001_0040, 32'h0);
        chk({q[15:0], q1[15:0]}, ~32'h0001_0040);
        x(hpad_pkg::CMD_DATA, 2'h0, 32'hbeef);
        x(hpad_pkg::CMD_DATA, 2'h1, 32'hdead);
        chk_req(1'h1, 32'h0001_0044, 32'hdead_beef);
        $display("test half word done");
    endtask : t_half
    task t_nonmux;
        page = 16'h8001;
        rst(hpad_pkg::MODE_NONMUX_FULL);
        ha = 16'h0010;
        x(hpad_pkg::CMD_CTRL, 2'h0, 32'hffff_fff0);
        chk(pcr, 32'hffff_fff0);
        ha = 16'h0020;
        x(hpad_pkg::CMD_DATA, 2'h0, 32'h1234_5678);
        chk_req(1'h1, 32'h8001_0020, 32'h1234_5678);
        ha = 16'h0024;
        x(hpad_pkg::CMD_DATA, 2'h2, 32'h0);
        chk_req(1'h0, 32'h8001_0024, 32'h0);
        chk(q, ~32'h8001_0024);
        x(hpad_pkg::CMD_CTRL, 2'h0, 32'h0011);
        chk(pcr, 32'h0011);
        ha = 16'h0;
        $display("test non-muxed done");
    endtask : t_nonmux
    task t_stall;
        rst(hpad_pkg::MODE_MUX_FULL);
        x(hpad_pkg::CMD_ADDR, 2'h0, 32'h3000);
        #2;
        stall = 1'h1;
        fork
            begin
                repeat (80) @(posedge mclk);
                #2;
                stall = 1'h0;
            end
        join_none
        for (int i = 0; i < 4; i++) x(hpad_pkg::CMD_DATA_INC, 2'h0, 32'ha000 + i);
        for (int i = 0; i < 4; i++) chk_req(1'h1, 32'h3000 + 4 * i, 32'ha000 + i);
        $display("test stall done");
    endtask : t_stall
    task results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    initial begin
        t_ctrl();
        t_inc();
        t_half();
        t_nonmux();
        t_stall();
        results();
    end
endmodule : hpad_host_port_tb_top
